// ### src/objctl_pkg.sv
// shared constants and types for the switchgear object controller
package objctl_pkg;
   // clock and documented-free timing defaults
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned PULSE_MAX_MS = 200;
   localparam int unsigned TIMEOUT_MS = 10_000;
   localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_MS * CYC_PER_MS;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_SRC = 8'h08;
   localparam logic [7:0] OFS_OUTSEL = 8'h0c;
   localparam logic [7:0] OFS_PULSE = 8'h10;
   localparam logic [7:0] OFS_TMO = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_OPN_CNT = 8'h1c;
   localparam logic [7:0] OFS_CLS_CNT = 8'h20;
   localparam logic [7:0] OFS_OPN_FAIL = 8'h24;
   localparam logic [7:0] OFS_CLS_FAIL = 8'h28;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

   // control register fields
   localparam int unsigned CTRL_REMOTE = 0;
   localparam int unsigned CTRL_TYPE_LSB = 1;
   localparam int unsigned CTRL_USE_RDY = 3;
   localparam int unsigned CTRL_USE_SYN = 4;
   // command register fields, write-one pulses
   localparam int unsigned CMD_OPEN = 0;
   localparam int unsigned CMD_CLOSE = 1;
   localparam int unsigned CMD_CLR = 2;
   // interrupt status fields
   localparam int unsigned EV_OPEN_FAIL = 0;
   localparam int unsigned EV_CLOSE_FAIL = 1;
   localparam int unsigned EV_BAD_POS = 2;
   localparam int unsigned EV_DONE = 3;
   localparam int unsigned N_EV = 4;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h04;
   localparam logic [15:0] SRC_RST = 16'h3210;
   localparam logic [7:0] OUTSEL_RST = 8'h10;

   // position, object kind and command sequencer state
   typedef enum logic [1:0] {POS_MID, POS_OPEN, POS_CLOSED, POS_BAD} pos_t;
   typedef enum logic [1:0] {
      GND_DISC, MOTOR_DISC, BREAKER, WD_BREAKER
   } obj_type_t;
   typedef enum logic [1:0] {ST_IDLE, ST_OPENING, ST_CLOSING} cmd_state_t;
endpackage : objctl_pkg

// ### src/object_control.sv
// switchgear object control with axi4-lite register slave
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
module object_control #(
   parameter int unsigned PULSE_MAX_DEF = objctl_pkg::PULSE_MAX_CYC,
   parameter int unsigned TIMEOUT_DEF = objctl_pkg::TIMEOUT_CYC,
   parameter int unsigned CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] di,
   input wire logic [7:0] lg,
   input wire logic local_open,
   input wire logic local_close,
   input wire logic app_open,
   input wire logic app_close,
   input wire logic ready_in,
   input wire logic sync_in,
   output logic [7:0] dout,
   output logic irq
);
   if (CNT_W < 1 || CNT_W > 32) begin : g_chk
      $error("CNT_W must lie between 1 and 32");
   end

   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   // pin inputs pass two flops before any logic reads them
   logic [11:0] meta_q;
   logic [11:0] pin_q;
   wire [11:0] pin_raw = {sync_in, ready_in, local_close, local_open, di};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         pin_q <= '0;
      end else begin
         meta_q <= pin_raw;
         pin_q <= meta_q;
      end
   end
   wire [7:0] di_s = pin_q[7:0];
   wire loc_open_s = pin_q[8];
   wire loc_close_s = pin_q[9];
   wire ready_s = pin_q[10];
   wire sync_s = pin_q[11];

   // configuration registers
   logic [7:0] ctrl_q;
   logic [15:0] src_q;
   logic [7:0] outsel_q;
   logic [31:0] pulse_q;
   logic [31:0] tmo_q;
   logic [3:0] mask_q;
   wire remote_q = ctrl_q[objctl_pkg::CTRL_REMOTE];
   wire use_rdy = ctrl_q[objctl_pkg::CTRL_USE_RDY];
   wire use_syn = ctrl_q[objctl_pkg::CTRL_USE_SYN];
   wire objctl_pkg::obj_type_t obj_type =
      objctl_pkg::obj_type_t'(ctrl_q[objctl_pkg::CTRL_TYPE_LSB +: 2]);
   wire withdrawable = (obj_type == objctl_pkg::WD_BREAKER);

   // position inputs each pick one of sixteen sources
   wire [15:0] src_bus = {lg, di_s};
   wire obj_open_in = src_bus[src_q[3:0]];
   wire obj_close_in = src_bus[src_q[7:4]];
   wire cart_in_in = src_bus[src_q[11:8]];
   wire cart_out_in = src_bus[src_q[15:12]];
   objctl_pkg::pos_t obj_pos;
   objctl_pkg::pos_t cart_raw;
   pos_decode u_obj_pos (
      .open_in(obj_open_in),
      .closed_in(obj_close_in),
      .pos(obj_pos)
   );
   pos_decode u_cart_pos (
      .open_in(cart_out_in),
      .closed_in(cart_in_in),
      .pos(cart_raw)
   );
   // a fixed object has no cart, so its cart status rests at travel
   wire objctl_pkg::pos_t cart_pos =
      withdrawable ? cart_raw : objctl_pkg::POS_MID;
   wire bad_now = (obj_pos == objctl_pkg::POS_BAD) ||
                  (cart_pos == objctl_pkg::POS_BAD);

   // axi write and read decode
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   wire wr_take = awready_q && awvalid && wready_q && wvalid;
   wire rd_take = arready_q && arvalid;
   wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                        {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire wr_ctrl = wr_take && awaddr == objctl_pkg::OFS_CTRL;
   wire wr_cmd = wr_take && awaddr == objctl_pkg::OFS_CMD && wstrb[0];
   wire wr_src = wr_take && awaddr == objctl_pkg::OFS_SRC;
   wire wr_outsel = wr_take && awaddr == objctl_pkg::OFS_OUTSEL;
   wire wr_pulse = wr_take && awaddr == objctl_pkg::OFS_PULSE;
   wire wr_tmo = wr_take && awaddr == objctl_pkg::OFS_TMO;
   wire wr_mask = wr_take && awaddr == objctl_pkg::OFS_IRQ_MASK;
   wire rd_irq = rd_take && araddr == objctl_pkg::OFS_IRQ_STAT;
   wire wr_known = wr_ctrl || wr_src || wr_outsel || wr_pulse ||
                   wr_tmo || wr_mask ||
                   (wr_take && awaddr == objctl_pkg::OFS_CMD);

   // command sequencer state
   objctl_pkg::cmd_state_t state_q;
   objctl_pkg::pos_t start_pos_q;
   logic [31:0] tcnt_q;
   logic lo_prev_q, lc_prev_q, ao_prev_q, ac_prev_q;
   wire idle = (state_q == objctl_pkg::ST_IDLE);
   wire changed = !idle && (obj_pos != start_pos_q);
   wire timed_out = !idle && !changed && (tcnt_q + 32'h1 >= tmo_q);
   wire pulse_on = !idle && !changed && (tcnt_q < pulse_q);

   // requests from bus, local pins and application signals
   wire bus_open = wr_cmd && wdata[objctl_pkg::CMD_OPEN] && remote_q;
   wire bus_close = wr_cmd && wdata[objctl_pkg::CMD_CLOSE] && remote_q;
   wire loc_open = loc_open_s && !lo_prev_q && !remote_q;
   wire loc_close = loc_close_s && !lc_prev_q && !remote_q;
   wire app_open_r = app_open && !ao_prev_q;
   wire app_close_r = app_close && !ac_prev_q;
   wire open_req = bus_open || loc_open || app_open_r;
   wire close_req = bus_close || loc_close || app_close_r;
   wire ready_ok = !use_rdy || ready_s;
   wire sync_ok = !use_syn || sync_s;
   wire open_allowed = idle;
   wire close_allowed = idle && ready_ok && sync_ok;
   // opening wins a tie, a safe choice for switchgear
   wire start_open = open_req && open_allowed;
   wire start_close = close_req && !open_req && close_allowed;
   wire fail_open = timed_out && state_q == objctl_pkg::ST_OPENING;
   wire fail_close = timed_out && state_q == objctl_pkg::ST_CLOSING;
   wire clr_stats = wr_cmd && wdata[objctl_pkg::CMD_CLR];

   // sequencer: one command at a time, ended by change or timeout
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= objctl_pkg::ST_IDLE;
         start_pos_q <= objctl_pkg::POS_MID;
         tcnt_q <= '0;
      end else if (idle) begin
         tcnt_q <= '0;
         start_pos_q <= obj_pos;
         if (start_open) state_q <= objctl_pkg::ST_OPENING;
         else if (start_close) state_q <= objctl_pkg::ST_CLOSING;
      end else if (changed || timed_out) begin
         state_q <= objctl_pkg::ST_IDLE;
      end else begin
         tcnt_q <= tcnt_q + 32'h1;
      end
   end

   // edge memories for level request inputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {lo_prev_q, lc_prev_q, ao_prev_q, ac_prev_q} <= '0;
      end else begin
         {lo_prev_q, lc_prev_q} <= {loc_open_s, loc_close_s};
         {ao_prev_q, ac_prev_q} <= {app_open, app_close};
      end
   end

   // outputs routed to the selected digital output
   wire [7:0] open_bit = 8'h01 << outsel_q[2:0];
   wire [7:0] close_bit = 8'h01 << outsel_q[6:4];
   wire [7:0] dout_d =
      (pulse_on && state_q == objctl_pkg::ST_OPENING) ? open_bit :
      (pulse_on && state_q == objctl_pkg::ST_CLOSING) ? close_bit :
      8'h00;
   logic [7:0] dout_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) dout_q <= '0;
      else dout_q <= dout_d;
   end
   assign dout = dout_q;

   // statistics; a request in the clearing cycle still counts once
   logic [CNT_W-1:0] opn_q, cls_q, opnf_q, clsf_q;
   wire [CNT_W-1:0] one = CNT_W'(1);
   always_ff @(posedge aclk) begin
      if (!aresetn || clr_stats) begin
         opn_q <= start_open ? one : '0;
         cls_q <= start_close ? one : '0;
         opnf_q <= fail_open ? one : '0;
         clsf_q <= fail_close ? one : '0;
      end else begin
         if (start_open) opn_q <= opn_q + one;
         if (start_close) cls_q <= cls_q + one;
         if (fail_open) opnf_q <= opnf_q + one;
         if (fail_close) clsf_q <= clsf_q + one;
      end
   end

   // sticky events, cleared by reading; a new event beats the clear
   logic [3:0] irq_stat_q;
   logic bad_prev_q;
   logic irq_q;
   wire [3:0] ev;
   assign ev[objctl_pkg::EV_OPEN_FAIL] = fail_open;
   assign ev[objctl_pkg::EV_CLOSE_FAIL] = fail_close;
   assign ev[objctl_pkg::EV_BAD_POS] = bad_now && !bad_prev_q;
   assign ev[objctl_pkg::EV_DONE] = changed;
   wire [3:0] irq_stat_d = (rd_irq ? 4'h0 : irq_stat_q) | ev;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
         bad_prev_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         bad_prev_q <= bad_now;
         irq_q <= |(irq_stat_d & mask_q);
      end
   end
   assign irq = irq_q;

   // configuration writes honour byte strobes
   wire [31:0] ctrl_w = ({24'h0, ctrl_q} & ~wmask) | (wdata & wmask);
   wire [31:0] src_w = ({16'h0, src_q} & ~wmask) | (wdata & wmask);
   wire [31:0] outs_w = ({24'h0, outsel_q} & ~wmask) | (wdata & wmask);
   wire [31:0] pulse_w = (pulse_q & ~wmask) | (wdata & wmask);
   wire [31:0] tmo_w = (tmo_q & ~wmask) | (wdata & wmask);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= objctl_pkg::CTRL_RST;
         src_q <= objctl_pkg::SRC_RST;
         outsel_q <= objctl_pkg::OUTSEL_RST;
         pulse_q <= 32'(PULSE_MAX_DEF);
         tmo_q <= 32'(TIMEOUT_DEF);
         mask_q <= '0;
      end else begin
         if (wr_ctrl) ctrl_q <= {3'h0, ctrl_w[4:0]};
         if (wr_src) src_q <= src_w[15:0];
         if (wr_outsel) outsel_q <= {1'b0, outs_w[6:4], 1'b0, outs_w[2:0]};
         if (wr_pulse) pulse_q <= pulse_w;
         if (wr_tmo) tmo_q <= tmo_w;
         if (wr_mask && wstrb[0]) mask_q <= wdata[3:0];
      end
   end

   // read selection
   wire [31:0] stat_w = {23'h0, !idle, sync_s, ready_s, close_allowed,
                         open_allowed, cart_pos, obj_pos};
   wire [7:0] ra = araddr;
   wire rd_known = ra == objctl_pkg::OFS_CTRL || ra == objctl_pkg::OFS_CMD ||
                   ra == objctl_pkg::OFS_SRC || ra == objctl_pkg::OFS_OUTSEL ||
                   ra == objctl_pkg::OFS_PULSE || ra == objctl_pkg::OFS_TMO ||
                   ra == objctl_pkg::OFS_STAT ||
                   ra == objctl_pkg::OFS_OPN_CNT ||
                   ra == objctl_pkg::OFS_CLS_CNT ||
                   ra == objctl_pkg::OFS_OPN_FAIL ||
                   ra == objctl_pkg::OFS_CLS_FAIL ||
                   ra == objctl_pkg::OFS_IRQ_STAT ||
                   ra == objctl_pkg::OFS_IRQ_MASK;
   wire [31:0] rd_word =
      ra == objctl_pkg::OFS_CTRL ? {24'h0, ctrl_q} :
      ra == objctl_pkg::OFS_SRC ? {16'h0, src_q} :
      ra == objctl_pkg::OFS_OUTSEL ? {24'h0, outsel_q} :
      ra == objctl_pkg::OFS_PULSE ? pulse_q :
      ra == objctl_pkg::OFS_TMO ? tmo_q :
      ra == objctl_pkg::OFS_STAT ? stat_w :
      ra == objctl_pkg::OFS_OPN_CNT ? 32'(opn_q) :
      ra == objctl_pkg::OFS_CLS_CNT ? 32'(cls_q) :
      ra == objctl_pkg::OFS_OPN_FAIL ? 32'(opnf_q) :
      ra == objctl_pkg::OFS_CLS_FAIL ? 32'(clsf_q) :
      ra == objctl_pkg::OFS_IRQ_STAT ? {28'h0, irq_stat_q} :
      ra == objctl_pkg::OFS_IRQ_MASK ? {28'h0, mask_q} : 32'h0;

   // axi handshakes: address and data are taken together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {awready_q, wready_q, bvalid_q, arready_q, rvalid_q} <= '0;
         bresp_q <= RESP_OK;
         rresp_q <= RESP_OK;
         rdata_q <= '0;
      end else begin
         awready_q <= !awready_q && !bvalid_q && awvalid && wvalid;
         wready_q <= !awready_q && !bvalid_q && awvalid && wvalid;
         if (wr_take) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? RESP_OK : RESP_ERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
         arready_q <= !arready_q && !rvalid_q && arvalid;
         if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_known ? RESP_OK : RESP_ERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // checks on the sequencer and status decode
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_local_blocks_bus: assert property (
      start_open && !app_open_r && !loc_open |-> remote_q)
      else $error("bus open accepted while local");
   a_intermediate_pos: assert property (
      !obj_open_in && !obj_close_in |-> obj_pos == objctl_pkg::POS_MID)
      else $error("both inputs low not intermediate");
   a_bad_pos_event: assert property (
      $rose(bad_now) |=> irq_stat_q[objctl_pkg::EV_BAD_POS])
      else $error("bad position event missing");
   a_open_pos: assert property (
      obj_open_in && !obj_close_in |-> obj_pos == objctl_pkg::POS_OPEN)
      else $error("open input not decoded as open");
   a_close_interlock: assert property (
      $rose(state_q == objctl_pkg::ST_CLOSING) |->
      $past(ready_ok) && $past(sync_ok))
      else $error("close started without permission");
   a_open_count: assert property (
      start_open && !clr_stats |=> opn_q == $past(opn_q) + one)
      else $error("open request not counted");
   a_clear_stats: assert property (
      clr_stats && idle && !start_open && !start_close |=>
      opn_q == '0 && cls_q == '0 && opnf_q == '0 && clsf_q == '0)
      else $error("statistics not cleared");
   a_pulse_cut: assert property (
      changed |=> dout_q == 8'h00 && idle)
      else $error("pulse not cut on position change");
   a_open_route: assert property (
      pulse_on && state_q == objctl_pkg::ST_OPENING |=> dout_q == $past(open_bit))
      else $error("open pulse on wrong output");
   a_timeout_fail: assert property (
      fail_close |=> idle && irq_stat_q[objctl_pkg::EV_CLOSE_FAIL] &&
      clsf_q != $past(clsf_q))
      else $error("timeout did not abort close");
endmodule : object_control

// ### src/pos_decode.sv
// two-contact position decoder
module pos_decode (
   input wire logic open_in,
   input wire logic closed_in,
   output objctl_pkg::pos_t pos
);
   // both low is travel, both high is a contact fault
   assign pos = (open_in && closed_in) ? objctl_pkg::POS_BAD :
                open_in ? objctl_pkg::POS_OPEN :
                closed_in ? objctl_pkg::POS_CLOSED :
                objctl_pkg::POS_MID;
endmodule : pos_decode

// ### verif/switchgear_model.sv
// switchgear model: two position contacts answering command pulses
module switchgear_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cmd_open,
   input wire logic cmd_close,
   input wire logic [7:0] delay,
   output logic open_fb,
   output logic closed_fb
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q;
   logic moving_q;
   logic target_q;
   // the contact leaves at once and the other lands delay plus one cycles later;
   // a pulse toward the present position moves nothing, as in real gear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_fb <= 1'b0;
         closed_fb <= 1'b1;
         moving_q <= 1'b0;
         cnt_q <= 8'h00;
         target_q <= 1'b1;
      end else if (moving_q) begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h00) begin
            moving_q <= 1'b0;
            open_fb <= ~target_q;
            closed_fb <= target_q;
         end
      end else if ((cmd_open && !open_fb) || (cmd_close && !closed_fb)) begin
         moving_q <= 1'b1;
         target_q <= ~cmd_open;
         cnt_q <= delay;
         open_fb <= 1'b0;
         closed_fb <= 1'b0;
      end
   end
endmodule : switchgear_model

// ### verif/switchgear_object_control_test.sv
// self-checking bench for the switchgear object controller
module switchgear_object_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned PULSE = 20;
   localparam int unsigned TMO = 50;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic local_open = 1'b0, local_close = 1'b0;
   logic app_open = 1'b0, app_close = 1'b0;
   logic ready_in = 1'b0, sync_in = 1'b0;
   logic [7:0] lg = 8'h00, noise_q = 8'h00, delay = 8'h01;
   logic [7:0] seen_q = 8'h00, run_q = 8'h00, mx_q = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] dout, di;
   logic clr = 1'b0, open_fb, closed_fb, pos_cl = 1'b1;
   int osel = 0, csel = 1;
   int unsigned n_fail = 0, total_checks = 0;
   int unsigned ecnt[4] = '{default: 0};

   always #25 aclk = ~aclk;
   assign di = {noise_q[3:0], 2'b00, closed_fb, open_fb};

   // upper four di pins get noise; watcher keeps fired outputs and longest pulse
   always @(posedge aclk) begin
      noise_q <= 8'($urandom);
      seen_q <= clr ? 8'h00 : seen_q | dout;
      run_q <= (|dout && !clr) ? run_q + 8'h01 : 8'h00;
      if (clr)
         mx_q <= 8'h00;
      else if (|dout && run_q >= mx_q)
         mx_q <= run_q + 8'h01;
   end

   object_control #(.PULSE_MAX_DEF(PULSE), .TIMEOUT_DEF(TMO))
   object_control_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .di(di), .lg(lg), .local_open(local_open),
      .local_close(local_close), .app_open(app_open),
      .app_close(app_close), .ready_in(ready_in), .sync_in(sync_in),
      .dout(dout), .irq(irq));

   switchgear_model switchgear_model_i (.aclk(aclk), .aresetn(aresetn),
      .cmd_open(dout[osel]), .cmd_close(dout[csel]), .delay(delay),
      .open_fb(open_fb), .closed_fb(closed_fb));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   // address and data go out together and each waits for its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // only the watchdog ends a wait; the slave may take either first
      while (!(ad && dd)) begin
         @(posedge aclk);
         ad = ad | awready;
         dd = dd | wready;
         if (ad)
            awvalid <= 1'b0;
         if (dd)
            wvalid <= 1'b0;
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   function automatic logic [1:0] pos_f(input logic op, input logic cl);
      return (op && cl) ? 2'd3 : cl ? 2'd2 : op ? 2'd1 : 2'd0;
   endfunction : pos_f

   // bus commands need remote, pins need local, application needs neither; closes also need enabled ready and sync
   function automatic logic acc_f(input int src, input logic [4:0] ctl,
                                  input logic rdy, input logic syn);
      logic a;
      a = (src < 2) ? ctl[0] : (src < 4) ? !ctl[0] : 1'b1;
      if (src % 2 == 1)
         a = a & (!ctl[3] | rdy) & (!ctl[4] | syn);
      return a;
   endfunction : acc_f

   task automatic cnt_chk;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 4; i++) begin
         rd(8'(objctl_pkg::OFS_OPN_CNT + 4 * i), d, r);
         chk(d, ecnt[i]);
      end
   endtask : cnt_chk

   // one request from source src, then outputs, position, events, counts
   task automatic op(input int src, input logic [4:0] ctl,
                     input logic rdy, input logic syn);
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] ev, msk;
      logic acc, mv;
      int cl;
      cl = src % 2;
      osel = $urandom % 8;
      csel = (osel + 1 + $urandom % 7) % 8;
      msk = 4'($urandom);
      delay <= 8'($urandom % 8 + 1);
      wr(objctl_pkg::OFS_CTRL, {27'h0, ctl}, r);
      wr(objctl_pkg::OFS_OUTSEL, 32'(csel * 16 + osel), r);
      wr(objctl_pkg::OFS_IRQ_MASK, {28'h0, msk}, r);
      ready_in <= rdy;
      sync_in <= syn;
      clr <= 1'b1;
      repeat (4) @(posedge aclk);
      clr <= 1'b0;
      rd(objctl_pkg::OFS_STAT, d, r);
      chk(d[8:4], {1'b0, syn, rdy, (!ctl[3] | rdy) & (!ctl[4] | syn), 1'b1});
      if (src < 2)
         wr(objctl_pkg::OFS_CMD, 32'(1 << src), r);
      else begin
         local_open <= src == 2;
         local_close <= src == 3;
         app_open <= src == 4;
         app_close <= src == 5;
         repeat (4) @(posedge aclk);
         {local_open, local_close, app_open, app_close} <= 4'h0;
      end
      repeat (6) @(posedge aclk);
      do rd(objctl_pkg::OFS_STAT, d, r); while (d[8] !== 1'b0);
      repeat (12) @(posedge aclk);
      acc = acc_f(src, ctl, rdy, syn);
      mv = acc && (cl == 1 ? !pos_cl : pos_cl);
      chk(seen_q, acc ? 8'(1 << (cl == 1 ? csel : osel)) : 8'h0);
      if (mv)
         chk(mx_q < PULSE, 1'b1);
      else if (acc)
         chk(mx_q >= PULSE - 1 && mx_q <= PULSE + 1, 1'b1);
      pos_cl = mv ? (cl == 1) : pos_cl;
      ecnt[cl] += acc;
      ecnt[2 + cl] += acc && !mv;
      rd(objctl_pkg::OFS_STAT, d, r);
      chk(d[1:0], pos_cl ? 2'd2 : 2'd1);
      ev = !acc ? 4'h0 : mv ? 4'h8 : (cl == 1 ? 4'h2 : 4'h1);
      chk(irq, |(ev & msk));
      rd(objctl_pkg::OFS_IRQ_STAT, d, r);
      chk(d[3:0], ev);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      cnt_chk;
   endtask : op

   // main sequence: reset values, decode walk, hand cases, random cases
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                             8'h30, 8'h1c};
      logic [31:0] rv[8] = '{32'h4, 32'h0, 32'h3210, 32'h10, PULSE, TMO,
                              32'h0, 32'h0};
      int hs[8] = '{0, 2, 3, 1, 1, 4, 5, 4};
      logic [4:0] hc[8] = '{4, 4, 5, 13, 13, 20, 21, 5};
      logic [1:0] hrs[8] = '{3, 3, 3, 1, 3, 0, 2, 3};
      void'($urandom(32'ha460));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      foreach (ra[i]) begin
         rd(ra[i], d, r);
         chk(d, rv[i]);
      end
      rd(8'h40, d, r);
      chk(r, 2'b10);
      wr(8'h40, 32'h1, r);
      chk(r, 2'b10);
      wr(objctl_pkg::OFS_SRC, 32'hba98, r);
      wr(objctl_pkg::OFS_CTRL, 32'h6, r);
      for (int i = 0; i < 16; i++) begin
         lg <= {4'($urandom), 4'(i)};
         repeat (3) @(posedge aclk);
         rd(objctl_pkg::OFS_STAT, d, r);
         chk(d[1:0], pos_f(i[0], i[1]));
         if (i[2] == i[3])
            chk(d[3:2], {i[3], i[3]});
      end
      wr(objctl_pkg::OFS_SRC, 32'h3210, r);
      wr(objctl_pkg::OFS_CTRL, 32'h4, r);
      repeat (8) @(posedge aclk);
      rd(objctl_pkg::OFS_IRQ_STAT, d, r);
      chk(d[2], 1'b1);
      foreach (hs[i])
         op(hs[i], hc[i], hrs[i][1], hrs[i][0]);
      repeat (30)
         op($urandom % 6, {2'($urandom), 2'b10, 1'($urandom)},
            1'($urandom), 1'($urandom));
      wr(objctl_pkg::OFS_CMD, 32'h4, r);
      ecnt = '{default: 0};
      cnt_chk;
      close_out;
   end

   // cuts a hang short well beyond the expected run length
   initial begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      close_out;
   end
endmodule : switchgear_object_control_test
